// >>> hdl/nv_host_regs.svh
// register offsets, fields and timing figures of the nvsram host controller
`ifndef NV_HOST_REGS_SVH
`define NV_HOST_REGS_SVH

// register byte offsets
`define NV_REG_CTRL      8'h00
`define NV_REG_ADDR      8'h04
`define NV_REG_WDATA     8'h08
`define NV_REG_RDATA     8'h0c
`define NV_REG_STATUS    8'h10
// fields
`define NV_CTRL_CMD_LSB  0
`define NV_CTRL_PERSIST  3
`define NV_STAT_BUSY     0
`define NV_STAT_PIN      1
`define NV_STAT_PULL     2
`define NV_STAT_READY    3
// reset values
`define NV_ADDR_RST      15'h0000
`define NV_BYTE_RST      8'h00
// bus answers
`define NV_RESP_OKAY     2'h0
`define NV_RESP_SLVERR   2'h2
// sequence addresses, lower 14 bits
`define NV_SEQ_A0        14'h0e38
`define NV_SEQ_A1        14'h31c7
`define NV_SEQ_A2        14'h03e0
`define NV_SEQ_A3        14'h3c1f
`define NV_SEQ_A4        14'h303f
`define NV_SEQ_STORE     14'h0fc0
`define NV_SEQ_RECALL    14'h0c63
`define NV_SEQ_SAVE_OFF  14'h0b45
`define NV_SEQ_SAVE_ON   14'h0b46
// times in ns and derived cycle counts
`define NV_CLK_NS            10
`define NV_T_ACCESS_NS       50
`define NV_T_STORE_REQ_NS    25000
`define NV_T_LOCKOUT_NS      20
`define NV_T_PWRUP_RECALL_NS 20000000
`define NV_T_SOFT_RECALL_NS  200
`define NV_T_STORE_CYCLE_NS  8000000
`define NV_CYC(t)        (((t) + `NV_CLK_NS - 1) / `NV_CLK_NS)
`define NV_SYNC_SLACK    3
`endif

// >>> hdl/nv_host_pkg.sv
// types of the nvsram host controller
package nv_host_pkg;
  typedef enum logic [2:0] {
    CMD_NONE      = 3'h0,
    CMD_READ      = 3'h1,
    CMD_WRITE     = 3'h2,
    CMD_SW_STORE  = 3'h3,
    CMD_SW_RECALL = 3'h4,
    CMD_SAVE_OFF  = 3'h5,
    CMD_SAVE_ON   = 3'h6,
    CMD_PIN_STORE = 3'h7
  } cmd_t;

  typedef enum logic [2:0] {
    ST_POWERUP,
    ST_IDLE,
    ST_STROBE,
    ST_GAP,
    ST_PULL,
    ST_WAIT_MIN,
    ST_WAIT_HIGH,
    ST_LOCK
  } state_t;
endpackage

// >>> hdl/nv_host_axi_regs.sv
// axi4-lite register file of the nvsram host controller
`timescale 1ns/100ps
`default_nettype none
`include "nv_host_regs.svh"
module nv_host_axi_regs (
  // clock and reset
  input  wire logic           sys_clk_i,
  input  wire logic           rst_b_i,
  // axi4-lite slave
  input  wire logic [7:0]     s_axi_awaddr_i,
  input  wire logic           s_axi_awvalid_i,
  output logic                s_axi_awready_o,
  input  wire logic [31:0]    s_axi_wdata_i,
  input  wire logic [3:0]     s_axi_wstrb_i,
  input  wire logic           s_axi_wvalid_i,
  output logic                s_axi_wready_o,
  output logic [1:0]          s_axi_bresp_o,
  output logic                s_axi_bvalid_o,
  input  wire logic           s_axi_bready_i,
  input  wire logic [7:0]     s_axi_araddr_i,
  input  wire logic           s_axi_arvalid_i,
  output logic                s_axi_arready_o,
  output logic [31:0]         s_axi_rdata_o,
  output logic [1:0]          s_axi_rresp_o,
  output logic                s_axi_rvalid_o,
  input  wire logic           s_axi_rready_i,
  // command to the sequencer
  output logic                cmd_valid_o,
  output nv_host_pkg::cmd_t   cmd_o,
  output logic                persist_o,
  output logic [14:0]         addr_o,
  output logic [7:0]          wdata_o,
  input  wire logic           cmd_take_i,
  // state from the sequencer
  input  wire logic [7:0]     rd_byte_i,
  input  wire logic [3:0]     status_i
);
  import nv_host_pkg::*;

  logic [7:0]  aw_addr;
  logic        aw_full;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_full;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire logic do_write = aw_full && w_full && !s_axi_bvalid_o;
  wire logic wr_ctrl  = do_write && aw_addr == `NV_REG_CTRL && w_strb[0];
  wire logic wr_addr  = do_write && aw_addr == `NV_REG_ADDR;
  wire logic wr_wdata = do_write && aw_addr == `NV_REG_WDATA && w_strb[0];
  wire logic wr_hit   = aw_addr == `NV_REG_CTRL || aw_addr == `NV_REG_ADDR ||
                        aw_addr == `NV_REG_WDATA;
  wire logic ar_take  = s_axi_arvalid_i && s_axi_arready_o;
  wire logic rd_hit   = s_axi_araddr_i == `NV_REG_CTRL ||
                        s_axi_araddr_i == `NV_REG_ADDR ||
                        s_axi_araddr_i == `NV_REG_WDATA ||
                        s_axi_araddr_i == `NV_REG_RDATA ||
                        s_axi_araddr_i == `NV_REG_STATUS;
  wire logic [31:0] rd_mux =
    s_axi_araddr_i == `NV_REG_CTRL   ? {28'h0000000, persist_o, cmd_o} :
    s_axi_araddr_i == `NV_REG_ADDR   ? {17'h00000, addr_o} :
    s_axi_araddr_i == `NV_REG_WDATA  ? {24'h000000, wdata_o} :
    s_axi_araddr_i == `NV_REG_RDATA  ? {24'h000000, rd_byte_i} :
    s_axi_araddr_i == `NV_REG_STATUS ? {28'h0000000, status_i} :
                                       32'h00000000;

  assign s_axi_awready_o = !aw_full;
  assign s_axi_wready_o  = !w_full;
  assign s_axi_arready_o = !s_axi_rvalid_o;

  ////////////////////////////////////////////////////////////////////////////
  // write channel capture and response
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      aw_full        <= 1'b0;
      w_full         <= 1'b0;
      aw_addr        <= 8'h00;
      w_data         <= 32'h00000000;
      w_strb         <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `NV_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_i && !aw_full)
      begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && !w_full)
      begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      if (do_write)
      begin
        aw_full        <= 1'b0;
        w_full         <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_hit ? `NV_RESP_OKAY : `NV_RESP_SLVERR;
      end
      else if (s_axi_bready_i)
        s_axi_bvalid_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; a command write while one is pending is dropped
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cmd_valid_o <= 1'b0;
      cmd_o       <= CMD_NONE;
      persist_o   <= 1'b0;
      addr_o      <= `NV_ADDR_RST;
      wdata_o     <= `NV_BYTE_RST;
    end
    else
    begin
      if (cmd_take_i)
        cmd_valid_o <= 1'b0;
      else if (wr_ctrl && !cmd_valid_o)
      begin
        cmd_valid_o <= 1'b1;
        cmd_o       <= cmd_t'(w_data[`NV_CTRL_CMD_LSB +: 3]);
        persist_o   <= w_data[`NV_CTRL_PERSIST];
      end
      if (wr_addr && w_strb[0])
        addr_o[7:0] <= w_data[7:0];
      if (wr_addr && w_strb[1])
        addr_o[14:8] <= w_data[14:8];
      if (wr_wdata)
        wdata_o <= w_data[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h00000000;
      s_axi_rresp_o  <= `NV_RESP_OKAY;
    end
    else if (ar_take)
    begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= rd_mux;
      s_axi_rresp_o  <= rd_hit ? `NV_RESP_OKAY : `NV_RESP_SLVERR;
    end
    else if (s_axi_rready_i)
      s_axi_rvalid_o <= 1'b0;
  end
endmodule
`default_nettype wire

// >>> hdl/nv_store_recall_control.sv
// host-side sequencer driving an nvsram over its async pins
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "nv_host_regs.svh"
module nv_store_recall_control #(
  parameter int unsigned ACC_CYC    = `NV_CYC(`NV_T_ACCESS_NS),
  parameter int unsigned REQ_CYC    = `NV_CYC(`NV_T_STORE_REQ_NS),
  parameter int unsigned LOCK_CYC   = `NV_CYC(`NV_T_LOCKOUT_NS),
  parameter int unsigned PWRUP_CYC  = `NV_CYC(`NV_T_PWRUP_RECALL_NS),
  parameter int unsigned RECALL_CYC = `NV_CYC(`NV_T_SOFT_RECALL_NS),
  parameter int unsigned STORE_CYC  = `NV_CYC(`NV_T_STORE_CYCLE_NS)
) (
  // clock and reset
  input  wire logic           sys_clk_i,
  input  wire logic           rst_b_i,
  // axi4-lite slave
  input  wire logic [7:0]     s_axi_awaddr_i,
  input  wire logic           s_axi_awvalid_i,
  output logic                s_axi_awready_o,
  input  wire logic [31:0]    s_axi_wdata_i,
  input  wire logic [3:0]     s_axi_wstrb_i,
  input  wire logic           s_axi_wvalid_i,
  output logic                s_axi_wready_o,
  output logic [1:0]          s_axi_bresp_o,
  output logic                s_axi_bvalid_o,
  input  wire logic           s_axi_bready_i,
  input  wire logic [7:0]     s_axi_araddr_i,
  input  wire logic           s_axi_arvalid_i,
  output logic                s_axi_arready_o,
  output logic [31:0]         s_axi_rdata_o,
  output logic [1:0]          s_axi_rresp_o,
  output logic                s_axi_rvalid_o,
  input  wire logic           s_axi_rready_i,
  // memory bus
  output logic [14:0]         mem_addr_o,
  output logic                mem_ce_n_o,
  output logic                mem_oe_n_o,
  output logic                mem_we_n_o,
  input  wire logic [7:0]     mem_dq_i,
  output logic [7:0]          mem_dq_o,
  output logic                mem_dq_oe_o,
  // open-drain busy pin
  input  wire logic           store_busy_n_i,
  output logic                store_busy_n_o,
  output logic                store_busy_n_oe_o
);
  import nv_host_pkg::*;

  state_t      state;
  cmd_t        op;
  logic [31:0] cnt;
  logic [2:0]  step;
  logic        in_seq;
  logic        chain;
  logic        ready;
  logic [7:0]  rd_byte;
  logic [1:0]  busy_sy;
  logic [7:0]  dq_s1;
  logic [7:0]  dq_s2;
  logic        cmd_valid;
  cmd_t        cmd;
  logic        persist;
  logic [14:0] reg_addr;
  logic [7:0]  reg_wdata;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] cyc_m1(input int unsigned n);
    cyc_m1 = (n == 0) ? 32'h00000000 : 32'(n - 1);
  endfunction

  // bit 14 held low; the device matches only the lower 14 bits
  function automatic logic [14:0] seq_addr(input logic [2:0] s,
                                           input cmd_t c);
    logic [13:0] a;
    a = `NV_SEQ_A0;
    case (s)
      3'h0: a = `NV_SEQ_A0;
      3'h1: a = `NV_SEQ_A1;
      3'h2: a = `NV_SEQ_A2;
      3'h3: a = `NV_SEQ_A3;
      3'h4: a = `NV_SEQ_A4;
      default:
        case (c)
          CMD_SW_RECALL: a = `NV_SEQ_RECALL;
          CMD_SAVE_OFF:  a = `NV_SEQ_SAVE_OFF;
          CMD_SAVE_ON:   a = `NV_SEQ_SAVE_ON;
          default:       a = `NV_SEQ_STORE;
        endcase
    endcase
    seq_addr = {1'b0, a};
  endfunction

  // wait after the sixth read before polling the busy pin
  function automatic logic [31:0] op_wait(input cmd_t c);
    case (c)
      CMD_SW_STORE:  op_wait = cyc_m1(STORE_CYC);
      CMD_SW_RECALL: op_wait = cyc_m1(RECALL_CYC);
      default:       op_wait = cyc_m1(`NV_SYNC_SLACK);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      busy_sy <= 2'h3;
      dq_s1   <= 8'h00;
      dq_s2   <= 8'h00;
    end
    else
    begin
      busy_sy <= {busy_sy[0], store_busy_n_i};
      dq_s1   <= mem_dq_i;
      dq_s2   <= dq_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire logic busy_high = busy_sy[1];
  wire logic cnt_done  = cnt == 32'h00000000;
  // no access starts while the pin is low
  wire logic cmd_take  = state == ST_IDLE && cmd_valid && busy_high;
  wire logic is_seq    = cmd == CMD_SW_STORE || cmd == CMD_SW_RECALL ||
                         cmd == CMD_SAVE_OFF || cmd == CMD_SAVE_ON;
  wire logic is_acc    = cmd == CMD_READ || cmd == CMD_WRITE;
  wire logic [31:0] strobe_len = cyc_m1(ACC_CYC + `NV_SYNC_SLACK);
  wire logic [3:0] status = {ready, store_busy_n_oe_o, busy_high,
                             state != ST_IDLE || cmd_valid};

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state             <= ST_POWERUP;
      cnt               <= cyc_m1(PWRUP_CYC);
      op                <= CMD_NONE;
      step              <= 3'h0;
      in_seq            <= 1'b0;
      chain             <= 1'b0;
      ready             <= 1'b0;
      rd_byte           <= `NV_BYTE_RST;
      mem_addr_o        <= `NV_ADDR_RST;
      mem_ce_n_o        <= 1'b1;
      mem_oe_n_o        <= 1'b1;
      mem_we_n_o        <= 1'b1;
      mem_dq_o          <= `NV_BYTE_RST;
      mem_dq_oe_o       <= 1'b0;
      store_busy_n_oe_o <= 1'b0;
    end
    else
    begin
      if (!cnt_done)
        cnt <= cnt - 32'h00000001;
      case (state)
        // device restores at power-up with the pin low
        ST_POWERUP:
          if (cnt_done)
            state <= ST_WAIT_HIGH;
        ST_IDLE:
          if (cmd_take)
          begin
            op     <= cmd;
            in_seq <= is_seq;
            step   <= 3'h0;
            chain  <= persist && (cmd == CMD_SAVE_OFF ||
                                  cmd == CMD_SAVE_ON);
            if (is_acc || is_seq)
            begin
              state       <= ST_STROBE;
              cnt         <= strobe_len;
              mem_addr_o  <= is_seq ? seq_addr(3'h0, cmd) : reg_addr;
              mem_ce_n_o  <= 1'b0;
              mem_oe_n_o  <= cmd == CMD_WRITE;
              mem_we_n_o  <= cmd != CMD_WRITE;
              mem_dq_o    <= reg_wdata;
              mem_dq_oe_o <= cmd == CMD_WRITE;
            end
            else if (cmd == CMD_PIN_STORE)
            begin
              state             <= ST_PULL;
              cnt               <= cyc_m1(REQ_CYC);
              store_busy_n_oe_o <= 1'b1;
            end
          end
        ST_STROBE:
          if (cnt_done)
          begin
            state       <= ST_GAP;
            mem_ce_n_o  <= 1'b1;
            mem_oe_n_o  <= 1'b1;
            mem_we_n_o  <= 1'b1;
            mem_dq_oe_o <= 1'b0;
            // the sixth read floats, so sequence reads are not kept
            if (op == CMD_READ)
              rd_byte <= dq_s2;
          end
        // one idle cycle splits strobes; nothing else fits in here
        ST_GAP:
          if (in_seq && step != 3'h5)
          begin
            state      <= ST_STROBE;
            step       <= step + 3'h1;
            cnt        <= strobe_len;
            mem_addr_o <= seq_addr(step + 3'h1, op);
            mem_ce_n_o <= 1'b0;
            mem_oe_n_o <= 1'b0;
          end
          else if (in_seq)
          begin
            state <= ST_WAIT_MIN;
            cnt   <= op_wait(op);
          end
          else
            state <= ST_IDLE;
        // release after the request delay; device then holds it only if it has unsaved data
        ST_PULL:
          if (cnt_done)
          begin
            store_busy_n_oe_o <= 1'b0;
            state             <= ST_WAIT_MIN;
            cnt               <= cyc_m1(`NV_SYNC_SLACK);
          end
        ST_WAIT_MIN:
          if (cnt_done)
            state <= ST_WAIT_HIGH;
        // whole save runs with the pin low
        ST_WAIT_HIGH:
          if (busy_high)
          begin
            state <= ST_LOCK;
            cnt   <= cyc_m1(LOCK_CYC);
          end
        ST_LOCK:
          if (cnt_done)
          begin
            ready <= 1'b1;
            if (chain)
            begin
              // new enable setting is kept only by a save
              chain      <= 1'b0;
              op         <= CMD_SW_STORE;
              in_seq     <= 1'b1;
              step       <= 3'h0;
              state      <= ST_STROBE;
              cnt        <= strobe_len;
              mem_addr_o <= seq_addr(3'h0, CMD_SW_STORE);
              mem_ce_n_o <= 1'b0;
              mem_oe_n_o <= 1'b0;
            end
            else
              state <= ST_IDLE;
          end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // open drain: only ever pulls low
  assign store_busy_n_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // register file
  nv_host_axi_regs u_regs (
    .sys_clk_i       (sys_clk_i),
    .rst_b_i         (rst_b_i),
    .s_axi_awaddr_i  (s_axi_awaddr_i),
    .s_axi_awvalid_i (s_axi_awvalid_i),
    .s_axi_awready_o (s_axi_awready_o),
    .s_axi_wdata_i   (s_axi_wdata_i),
    .s_axi_wstrb_i   (s_axi_wstrb_i),
    .s_axi_wvalid_i  (s_axi_wvalid_i),
    .s_axi_wready_o  (s_axi_wready_o),
    .s_axi_bresp_o   (s_axi_bresp_o),
    .s_axi_bvalid_o  (s_axi_bvalid_o),
    .s_axi_bready_i  (s_axi_bready_i),
    .s_axi_araddr_i  (s_axi_araddr_i),
    .s_axi_arvalid_i (s_axi_arvalid_i),
    .s_axi_arready_o (s_axi_arready_o),
    .s_axi_rdata_o   (s_axi_rdata_o),
    .s_axi_rresp_o   (s_axi_rresp_o),
    .s_axi_rvalid_o  (s_axi_rvalid_o),
    .s_axi_rready_i  (s_axi_rready_i),
    .cmd_valid_o     (cmd_valid),
    .cmd_o           (cmd),
    .persist_o       (persist),
    .addr_o          (reg_addr),
    .wdata_o         (reg_wdata),
    .cmd_take_i      (cmd_take),
    .rd_byte_i       (rd_byte),
    .status_i        (status)
  );
endmodule
`default_nettype wire

// >>> verif/nv_mem_model.sv
// behavioural nvsram standing on the far side of the controller
`timescale 1ns/100ps
`default_nettype none
`include "nv_host_regs.svh"
module nv_mem_model #(
  parameter int SAVE_CYC  = 12,
  parameter int PWRUP_CYC = 30
) (
  // clock and power
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  // memory pins
  input  wire logic [14:0] addr_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [7:0]  dq_i,
  output logic [7:0]       dq_o,
  // busy pin
  input  wire logic        busy_pin_i,
  output logic             pull_o
);
  localparam logic [13:0] SEQ [5] = '{`NV_SEQ_A0, `NV_SEQ_A1, `NV_SEQ_A2,
    `NV_SEQ_A3, `NV_SEQ_A4};
  logic [7:0]  mem [0:32767];
  logic [7:0]  nv  [0:32767];
  logic [13:0] a;
  logic [7:0]  junk;
  logic [7:0]  saves = 8'h00;
  logic [7:0]  recalls = 8'h00;
  logic        auto_en = 1'b1;
  logic        rd;
  logic        rd_q;
  logic        dirty;
  int          hold;
  int          step;
  assign rd = !ce_n_i && !oe_n_i && we_n_i;
  assign a = addr_i[13:0];
  // disabled lines toggle so a stale byte never looks valid
  assign dq_o = (rd && hold == 0) ? mem[addr_i] : junk;
  task save();
    foreach (mem[i]) nv[i] = mem[i];
    dirty = 1'b0;
    saves++;
    hold = SAVE_CYC;
    pull_o <= 1'b1;
  endtask
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      if (auto_en && dirty) foreach (mem[i]) nv[i] = mem[i];
      hold = PWRUP_CYC;
      pull_o <= 1'b1;
      step = 0;
      dirty = 1'b0;
      rd_q = 1'b0;
      junk = 8'h5a;
    end
    else
    begin
      junk = ~junk;
      if (hold > 0)
      begin
        hold = hold - 1;
        pull_o <= pull_o && hold != 0;
      end
      else if (!busy_pin_i)
      begin
        if (dirty)
          save();
      end
      else if (!ce_n_i && !we_n_i)
      begin
        mem[addr_i] = dq_i;
        dirty = 1'b1;
        step = 0;
      end
      else if (rd_q && !rd)
      begin
        if (step < 5)
          step = (a == SEQ[step]) ? step + 1 : int'(a == SEQ[0]);
        else
        begin
          step = 0;
          case (a)
            `NV_SEQ_STORE: save();
            `NV_SEQ_RECALL:
            begin
              foreach (mem[i]) mem[i] = nv[i];
              dirty = 1'b0;
              recalls++;
              hold = 2;
            end
            `NV_SEQ_SAVE_OFF: auto_en = 1'b0;
            `NV_SEQ_SAVE_ON: auto_en = 1'b1;
            default: step = int'(a == SEQ[0]);
          endcase
        end
      end
      rd_q = rd;
    end
  end
endmodule
`default_nettype wire

// >>> verif/nv_store_recall_control_checker.sv
// pin and bus assertions of the nvsram host controller
`timescale 1ns/100ps
`default_nettype none
module nv_store_recall_control_checker #(
  parameter int unsigned ACC_CYC = 5,
  parameter int unsigned REQ_CYC = 8
) (
  input wire logic        sys_clk_i,
  input wire logic        rst_b_i,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [14:0] mem_addr_o,
  input wire logic        mem_ce_n_o,
  input wire logic        mem_oe_n_o,
  input wire logic        mem_we_n_o,
  input wire logic        mem_dq_oe_o,
  input wire logic        store_busy_n_i,
  input wire logic        store_busy_n_o,
  input wire logic        store_busy_n_oe_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [15:0] strobe_len, pull_len;
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      strobe_len <= 16'h0000;
      pull_len   <= 16'h0000;
    end
    else
    begin
      strobe_len <= mem_ce_n_o ? 16'h0000 : strobe_len + 16'h0001;
      pull_len   <= store_busy_n_oe_o ? pull_len + 16'h0001 : 16'h0000;
    end
  end
  AST_STROBE_LEN: assert property
    ($rose(mem_ce_n_o) |-> strobe_len == ACC_CYC + 3)
    else $error("strobe length wrong");
  AST_PULL_LEN: assert property
    ($fell(store_busy_n_oe_o) |-> pull_len == REQ_CYC)
    else $error("pin request length wrong");
  AST_OPEN_DRAIN: assert property
    (store_busy_n_o == 1'b0)
    else $error("busy pin driven high");
  AST_QUIET_PULL: assert property
    (store_busy_n_oe_o |-> mem_ce_n_o && mem_we_n_o)
    else $error("access while pulling busy");
  AST_START_HIGH: assert property
    ($fell(mem_ce_n_o) |-> $past(store_busy_n_i) && $past(store_busy_n_i, 2))
    else $error("access started while busy");
  AST_LOCKOUT: assert property
    ($rose(store_busy_n_i) |-> mem_ce_n_o [*4])
    else $error("access inside lockout");
  AST_DQ_WRITE: assert property
    (mem_dq_oe_o |-> !mem_we_n_o && !mem_ce_n_o && mem_oe_n_o)
    else $error("data driven outside write");
  AST_ADDR_HELD: assert property
    (!mem_ce_n_o && !$fell(mem_ce_n_o) |-> $stable(mem_addr_o))
    else $error("address moved in strobe");
  AST_R_HOLD: assert property
    (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read answer dropped");
  cover property ($fell(store_busy_n_oe_o));
  cover property ($rose(mem_we_n_o));
  cover property ($rose(store_busy_n_i) && !store_busy_n_oe_o);
endmodule
bind nv_store_recall_control nv_store_recall_control_checker #(
  .ACC_CYC(ACC_CYC), .REQ_CYC(REQ_CYC)) i_chk (.sys_clk_i, .rst_b_i,
  .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o, .mem_addr_o, .mem_ce_n_o,
  .mem_oe_n_o, .mem_we_n_o, .mem_dq_oe_o, .store_busy_n_i, .store_busy_n_o,
  .store_busy_n_oe_o);
`default_nettype wire

// >>> verif/tb_nv_store_recall_control.sv
// self-checking bench of the nvsram host controller
`timescale 1ns/100ps
`default_nettype none
`include "nv_host_regs.svh"
module tb_nv_store_recall_control;
  import nv_host_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        rst_b_i = 1'b1;
  logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, data;
  logic [3:0]  s_axi_wstrb_i = 4'hf;
  logic        s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
  logic        s_axi_arvalid_i = 0, s_axi_rready_i = 0, s_axi_awready_o;
  logic        s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, resp;
  logic [14:0] mem_addr_o;
  logic [7:0]  mem_dq_i, mem_dq_o, s0;
  logic        mem_ce_n_o, mem_oe_n_o, mem_we_n_o, mem_dq_oe_o, pull;
  logic        store_busy_n_o, store_busy_n_oe_o;
  wire         store_busy_n_i;
  int          err_total = 0;
  int          tests_run = 0;
  // pull-up on the pin; either party may sink it
  assign store_busy_n_i = !((store_busy_n_oe_o && !store_busy_n_o) || pull);
  always #5 sys_clk_i = ~sys_clk_i;
  nv_store_recall_control #(.REQ_CYC(8),
    .PWRUP_CYC(20), .RECALL_CYC(5), .STORE_CYC(20)) i_dut (.sys_clk_i,
    .rst_b_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .mem_addr_o, .mem_ce_n_o, .mem_oe_n_o,
    .mem_we_n_o, .mem_dq_i, .mem_dq_o, .mem_dq_oe_o, .store_busy_n_i,
    .store_busy_n_o, .store_busy_n_oe_o);
  nv_mem_model i_mem (.sys_clk_i, .rst_b_i, .addr_i(mem_addr_o),
    .ce_n_i(mem_ce_n_o), .oe_n_i(mem_oe_n_o), .we_n_i(mem_we_n_o),
    .dq_i(mem_dq_o), .dq_o(mem_dq_i), .busy_pin_i(store_busy_n_i),
    .pull_o(pull));
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic guard(input int n);
    if (n >= 200)
    begin
      err_total++;
      $display("wrong value at %0t: no answer", $time);
      stop_test();
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    int n;
    n = 0;
    @(posedge sys_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do
    begin
      @(negedge sys_clk_i);
      aw = s_axi_awvalid_i && s_axi_awready_o;
      w = s_axi_wvalid_i && s_axi_wready_o;
      b = s_axi_bvalid_o;
      resp = s_axi_bresp_o;
      @(posedge sys_clk_i);
      if (aw) s_axi_awvalid_i <= 1'b0;
      if (w) s_axi_wvalid_i <= 1'b0;
      n++;
      guard(n);
    end while (b !== 1'b1);
    s_axi_bready_i <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ar, r, v;
    int n;
    n = 0;
    @(posedge sys_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    do
    begin
      @(negedge sys_clk_i);
      ar = s_axi_arvalid_i && s_axi_arready_o;
      v = s_axi_rvalid_o;
      r = v && s_axi_rready_i;
      data = s_axi_rdata_o;
      resp = s_axi_rresp_o;
      @(posedge sys_clk_i);
      if (ar) s_axi_arvalid_i <= 1'b0;
      // late ready lets the answer stand one cycle
      s_axi_rready_i <= v && !r;
      n++;
      guard(n);
    end while (r !== 1'b1);
  endtask
  // one command, then poll until the sequencer is idle again
  task automatic op(input cmd_t c, input logic keep);
    int n;
    axi_wr(`NV_REG_CTRL, {28'h0, keep, c});
    n = 0;
    do
    begin
      axi_rd(`NV_REG_STATUS);
      n++;
      guard(n);
    end while (data[`NV_STAT_BUSY] !== 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    axi_rd(`NV_REG_ADDR);
    check(data, 32'h0);
    axi_rd(8'h14);
    check({data[29:0], resp}, {30'h0, `NV_RESP_SLVERR});
    axi_wr(8'h1c, 32'h1);
    check(resp, `NV_RESP_SLVERR);
    op(CMD_NONE, 1'b0);
    check(data[`NV_STAT_READY], 1'b1);
  endtask
  task automatic t_rw();
    axi_wr(`NV_REG_ADDR, 32'h4e38);
    axi_wr(`NV_REG_WDATA, 32'h5a);
    op(CMD_WRITE, 1'b0);
    check(i_mem.mem[15'h4e38], 8'h5a);
    axi_wr(`NV_REG_WDATA, 32'h0);
    op(CMD_READ, 1'b0);
    axi_rd(`NV_REG_RDATA);
    check(data, 32'h5a);
  endtask
  task automatic t_store();
    s0 = i_mem.saves;
    op(CMD_SW_STORE, 1'b0);
    check(i_mem.saves, s0 + 8'h01);
    op(CMD_SW_STORE, 1'b0);
    check(i_mem.saves, s0 + 8'h02);
    check(i_mem.nv[15'h4e38], 8'h5a);
  endtask
  task automatic t_pin();
    s0 = i_mem.saves;
    op(CMD_PIN_STORE, 1'b0);
    check(i_mem.saves, s0);
    op(CMD_WRITE, 1'b0);
    op(CMD_PIN_STORE, 1'b0);
    check(i_mem.saves, s0 + 8'h01);
    check(data[2:1], 2'b01);
  endtask
  task automatic t_auto();
    op(CMD_SAVE_OFF, 1'b0);
    check(i_mem.auto_en, 1'b0);
    s0 = i_mem.saves;
    op(CMD_SAVE_ON, 1'b1);
    check(i_mem.auto_en, 1'b1);
    check(i_mem.saves, s0 + 8'h01);
  endtask
  task automatic t_recall();
    axi_wr(`NV_REG_WDATA, 32'h77);
    op(CMD_WRITE, 1'b0);
    s0 = i_mem.recalls;
    op(CMD_SW_RECALL, 1'b0);
    check(i_mem.recalls, s0 + 8'h01);
    op(CMD_READ, 1'b0);
    axi_rd(`NV_REG_RDATA);
    check(data, 32'h00);
  endtask
  initial
  begin
    rst_b_i <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    t_regs();
    t_rw();
    t_store();
    t_pin();
    t_auto();
    t_recall();
    stop_test();
  end
endmodule
`default_nettype wire
